/* rtl/pnl_pkg.sv */
// Shared constants, types and helpers for the peer-link framer and election
package pnl_pkg;

  // ==========================================================================
  // Widths and table sizes
  localparam int VLAN_W      = 12;
  localparam int CLIENT_W    = 9;
  localparam int TAG_W       = 16;
  localparam int NUM_CLIENTS = 512;
  localparam int WAIT_CNT_W  = 25;

  // ==========================================================================
  // Header field values
  localparam logic [TAG_W-1:0] TAG_EDGE  = 16'hFFFE;
  localparam logic [15:0]      FGID_BASE = 16'h1000;

  // ==========================================================================
  // Reachability entry codes and body lengths
  localparam logic [7:0] RT_AUTO_DISC  = 8'h01;
  localparam logic [7:0] RT_MAC_IP     = 8'h02;
  localparam logic [7:0] RT_INCL_MCAST = 8'h03;
  localparam logic [7:0] RT_SEGMENT    = 8'h04;
  localparam logic [7:0] RT_AD_LEN     = 8'h19;
  localparam logic [7:0] RT_SEG_LEN    = 8'h17;

  // ==========================================================================
  // Election wait: time in seconds, clock rate, derived cycle count
  localparam int unsigned FL_WAIT_S      = 3;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned FL_WAIT_CYCLES = FL_WAIT_S * CLK_HZ;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_ELECT = 2'b11
  } pnl_state_e;

  typedef struct packed {
    logic                flood;
    logic                from_edge;
    logic                to_peer;
    logic [CLIENT_W-1:0] client;
    logic [VLAN_W-1:0]   vlan;
  } pnl_ingress_s;

  typedef struct packed {
    logic [15:0]      bridge_domain;
    logic             mflag;
    logic [TAG_W-1:0] tag;
  } pnl_nsh_s;

  typedef struct packed {
    logic                flood;
    logic                unicast;
    logic [15:0]         flood_group_id;
    logic                suppress_en;
    logic [CLIENT_W-1:0] suppress_client;
    logic                learn;
  } pnl_rx_s;

  typedef struct packed {
    logic [7:0]          rtype;
    logic [7:0]          len;
    logic                withdraw;
    logic [CLIENT_W-1:0] client;
  } pnl_route_s;

  // ==========================================================================
  // Helpers
  function automatic logic [TAG_W-1:0] client_tag(
    input logic [CLIENT_W-1:0] client);
    client_tag = {{(TAG_W-CLIENT_W){1'b0}}, client};
  endfunction

  function automatic logic [15:0] vlan_fgid(input logic [VLAN_W-1:0] vlan);
    vlan_fgid = FGID_BASE | {4'h0, vlan};
  endfunction

endpackage

/* rtl/pnl_nsh_encap.sv */
// Registered header builder for frames leaving toward the peer link
`timescale 1ns/1ps
module pnl_nsh_encap (
  // Clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rst_n_i,
  // Ingress frame descriptor
  input  wire logic            in_valid_i,
  input  pnl_pkg::pnl_ingress_s in_desc_i,
  // Header toward the peer link, or local switching
  output pnl_pkg::pnl_nsh_s    nsh_o,
  output logic                 nsh_valid_o,
  output logic                 local_l2_o
);
  import pnl_pkg::*;

  pnl_nsh_s next_nsh;
  logic     next_nsh_valid;
  logic     next_local_l2;

  // Header fields from ingress kind; tag is reserved value or client tag
  always_comb begin
    next_nsh_valid = in_valid_i & in_desc_i.to_peer;
    next_local_l2  = in_valid_i & ~in_desc_i.to_peer;
    next_nsh.bridge_domain = {4'h0, in_desc_i.vlan};
    next_nsh.mflag = in_desc_i.flood;
    if (in_desc_i.from_edge) begin
      next_nsh.tag = TAG_EDGE;
    end else begin
      // Same on elected and non-elected node: peer needs it to suppress
      next_nsh.tag = client_tag(in_desc_i.client);
    end
    // Unicast from a client gets flag zero and its own tag
    if (!in_desc_i.flood && !in_desc_i.from_edge) begin
      next_nsh.mflag = 1'b0;
    end
  end

  // Output stage
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nsh_o       <= '0;
      nsh_valid_o <= 1'b0;
      local_l2_o  <= 1'b0;
    end else begin
      nsh_o       <= next_nsh;
      nsh_valid_o <= next_nsh_valid;
      local_l2_o  <= next_local_l2;
    end
  end

endmodule

/* rtl/pnl_peer_link_df.sv */
// Peer-link data plane and elected-flooder logic for a dual-homed pair
`timescale 1ns/1ps
module pnl_peer_link_fl #(
  parameter int unsigned WAIT_CYCLES = pnl_pkg::FL_WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  // Configuration and node state
  input  wire logic                     lb_enable_i,
  input  wire logic [31:0]              own_ip_i,
  input  wire logic [31:0]              peer_ip_i,
  input  wire logic                     peer_node_up_i,
  input  wire logic                     session_up_i,
  // Ingress frames from local ports
  input  wire logic                     in_valid_i,
  input  pnl_pkg::pnl_ingress_s         in_desc_i,
  // Frames received from the peer link
  input  wire logic                     rx_valid_i,
  input  pnl_pkg::pnl_nsh_s             rx_hdr_i,
  // Client deploy and client port events
  input  wire logic                     cl_evt_valid_i,
  input  wire logic [pnl_pkg::CLIENT_W-1:0] cl_evt_client_i,
  input  wire logic                     cl_evt_deploy_i,
  input  wire logic                     port_evt_valid_i,
  input  wire logic [pnl_pkg::CLIENT_W-1:0] port_evt_client_i,
  input  wire logic                     port_evt_up_i,
  input  wire logic                     seg_fail_valid_i,
  input  wire logic [pnl_pkg::CLIENT_W-1:0] seg_fail_client_i,
  // Routes received from the peer
  input  wire logic                     rt_rx_valid_i,
  input  pnl_pkg::pnl_route_s           rt_rx_i,
  // Egress eligibility query
  input  wire logic                     egr_valid_i,
  input  wire logic [pnl_pkg::CLIENT_W-1:0] egr_client_i,
  input  wire logic [pnl_pkg::VLAN_W-1:0]   egr_vlan_i,
  // Header toward the peer link
  output pnl_pkg::pnl_nsh_s             nsh_o,
  output logic                          nsh_valid_o,
  output logic                          local_l2_o,
  // Decision for frames from the peer link
  output pnl_pkg::pnl_rx_s              rx_dec_o,
  output logic                          rx_dec_valid_o,
  // Routes sent to the peer
  output pnl_pkg::pnl_route_s           rt_tx_o,
  output logic                          rt_tx_valid_o,
  // MAC flush request
  output logic                          mac_flush_o,
  output logic [pnl_pkg::CLIENT_W-1:0]  mac_flush_client_o,
  // Election results
  output logic                          egr_allow_o,
  output logic                          egr_allow_valid_o,
  output logic                          fl_global_o,
  output logic                          elect_busy_o
);
  import pnl_pkg::*;

  // ==========================================================================
  // Header builder
  pnl_nsh_encap u_encap (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (in_valid_i),
    .in_desc_i   (in_desc_i),
    .nsh_o       (nsh_o),
    .nsh_valid_o (nsh_valid_o),
    .local_l2_o  (local_l2_o)
  );

  // ==========================================================================
  // Receive decision
  pnl_rx_s next_rx_dec;
  logic    next_rx_dec_valid;

  // Suppression only for client-originated floods; unicast stays plain L2
  always_comb begin
    next_rx_dec_valid            = rx_valid_i;
    next_rx_dec.flood            = rx_hdr_i.mflag;
    next_rx_dec.unicast          = ~rx_hdr_i.mflag;
    next_rx_dec.flood_group_id   =
      vlan_fgid(rx_hdr_i.bridge_domain[VLAN_W-1:0]);
    next_rx_dec.suppress_en      =
      rx_hdr_i.mflag & (rx_hdr_i.tag != TAG_EDGE);
    next_rx_dec.suppress_client  = rx_hdr_i.tag[CLIENT_W-1:0];
    next_rx_dec.learn            = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_dec_o       <= '0;
      rx_dec_valid_o <= 1'b0;
    end else begin
      rx_dec_o       <= next_rx_dec;
      rx_dec_valid_o <= next_rx_dec_valid;
    end
  end

  // ==========================================================================
  // Segment presence tables, one bit per client
  logic [NUM_CLIENTS-1:0] loc_seg;
  logic [NUM_CLIENTS-1:0] peer_seg;
  logic [NUM_CLIENTS-1:0] next_loc_seg;
  logic [NUM_CLIENTS-1:0] next_peer_seg;
  logic                   rt_seg_rx;
  logic                   rt_ad_rx;

  // Only the two election-relevant types act; others are for software
  assign rt_seg_rx = rt_rx_valid_i & (rt_rx_i.rtype == RT_SEGMENT);
  assign rt_ad_rx  = rt_rx_valid_i & (rt_rx_i.rtype == RT_AUTO_DISC);

  always_comb begin
    next_loc_seg  = loc_seg;
    next_peer_seg = peer_seg;
    if (cl_evt_valid_i) begin
      next_loc_seg[cl_evt_client_i] = cl_evt_deploy_i;
    end
    // Failure last so it wins over a deploy of the same client
    if (seg_fail_valid_i) begin
      next_loc_seg[seg_fail_client_i] = 1'b0;
    end
    if (rt_seg_rx) begin
      next_peer_seg[rt_rx_i.client] = ~rt_rx_i.withdraw;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loc_seg  <= '0;
      peer_seg <= '0;
    end else begin
      loc_seg  <= next_loc_seg;
      peer_seg <= next_peer_seg;
    end
  end

  // ==========================================================================
  // Route transmit and MAC flush
  pnl_route_s          next_rt_tx;
  logic                next_rt_tx_valid;
  logic                next_mac_flush;
  logic [CLIENT_W-1:0] next_mac_flush_client;

  // One route per cycle: failure, then deploy, then port change
  always_comb begin
    next_rt_tx       = '0;
    next_rt_tx_valid = 1'b0;
    if (seg_fail_valid_i) begin
      next_rt_tx_valid    = 1'b1;
      next_rt_tx.rtype    = RT_SEGMENT;
      next_rt_tx.len      = RT_SEG_LEN;
      next_rt_tx.withdraw = 1'b1;
      next_rt_tx.client   = seg_fail_client_i;
    end else if (cl_evt_valid_i) begin
      next_rt_tx_valid    = 1'b1;
      next_rt_tx.rtype    = RT_SEGMENT;
      next_rt_tx.len      = RT_SEG_LEN;
      next_rt_tx.withdraw = ~cl_evt_deploy_i;
      next_rt_tx.client   = cl_evt_client_i;
    end else if (port_evt_valid_i) begin
      next_rt_tx_valid    = 1'b1;
      next_rt_tx.rtype    = RT_AUTO_DISC;
      next_rt_tx.len      = RT_AD_LEN;
      next_rt_tx.withdraw = ~port_evt_up_i;
      next_rt_tx.client   = port_evt_client_i;
    end
    // Peer withdrew its discovery route: flush all MACs on that port
    next_mac_flush        = rt_ad_rx & rt_rx_i.withdraw;
    next_mac_flush_client = rt_rx_i.client;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rt_tx_o            <= '0;
      rt_tx_valid_o      <= 1'b0;
      mac_flush_o        <= 1'b0;
      mac_flush_client_o <= '0;
    end else begin
      rt_tx_o            <= next_rt_tx;
      rt_tx_valid_o      <= next_rt_tx_valid;
      mac_flush_o        <= next_mac_flush;
      mac_flush_client_o <= next_mac_flush_client;
    end
  end

  // ==========================================================================
  // Election triggers and wait timer
  pnl_state_e            state;
  pnl_state_e            next_state;
  logic [WAIT_CNT_W-1:0] wait_cnt;
  logic [WAIT_CNT_W-1:0] next_wait_cnt;
  logic                  peer_up_q;
  logic                  session_q;
  logic                  start_wait;
  logic                  elect_now;

  // Deploys and session up wait for the peer's route before electing
  assign start_wait = (cl_evt_valid_i & cl_evt_deploy_i)
                    | (session_up_i & ~session_q);
  // Peer route change, port change, failure or node change: no wait
  assign elect_now = rt_seg_rx | rt_ad_rx
                   | port_evt_valid_i
                   | seg_fail_valid_i
                   | (cl_evt_valid_i & ~cl_evt_deploy_i)
                   | (peer_node_up_i ^ peer_up_q);

  always_comb begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    case (state)
      ST_IDLE: begin
        if (elect_now) begin
          next_state = ST_ELECT;
        end else if (start_wait) begin
          next_state    = ST_WAIT;
          next_wait_cnt = WAIT_CNT_W'(WAIT_CYCLES - 1);
        end
      end
      ST_WAIT: begin
        if (elect_now || wait_cnt == '0) begin
          next_state = ST_ELECT;
        end else if (start_wait) begin
          next_wait_cnt = WAIT_CNT_W'(WAIT_CYCLES - 1);
        end else begin
          next_wait_cnt = wait_cnt - 1'b1;
        end
      end
      ST_ELECT: begin
        // A deploy during the election cycle still gets its full wait
        if (start_wait) begin
          next_state    = ST_WAIT;
          next_wait_cnt = WAIT_CNT_W'(WAIT_CYCLES - 1);
        end else begin
          next_state = elect_now ? ST_ELECT : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= ST_IDLE;
      wait_cnt  <= '0;
      peer_up_q <= 1'b0;
      session_q <= 1'b0;
    end else begin
      state     <= next_state;
      wait_cnt  <= next_wait_cnt;
      peer_up_q <= peer_node_up_i;
      session_q <= session_up_i;
    end
  end

  // ==========================================================================
  // Election snapshot and single-flooder state
  logic [NUM_CLIENTS-1:0] snap_peer;
  logic [NUM_CLIENTS-1:0] next_snap_peer;
  logic                   own_ord;
  logic                   next_own_ord;
  logic                   fl_known;
  logic                   next_fl_known;
  logic                   fl_global;
  logic                   next_fl_global;
  logic                   local_port_down;
  logic                   peer_port_down;

  assign local_port_down = port_evt_valid_i & ~port_evt_up_i;
  assign peer_port_down  = rt_ad_rx & rt_rx_i.withdraw;

  always_comb begin
    next_snap_peer = snap_peer;
    next_own_ord   = own_ord;
    next_fl_known  = fl_known;
    next_fl_global = fl_global;
    if (state == ST_ELECT) begin
      // Peer counts only while its node is up; ascending, from zero
      next_snap_peer = peer_seg & {NUM_CLIENTS{peer_node_up_i}};
      next_own_ord   = peer_node_up_i & (own_ip_i > peer_ip_i);
      if (!fl_known) begin
        next_fl_known  = 1'b1;
        next_fl_global = ~peer_node_up_i | (own_ip_i < peer_ip_i);
      end
    end
    // Moves only when the flooder itself or its port fails
    if (fl_known && fl_global && local_port_down) begin
      next_fl_global = 1'b0;
    end else if (fl_known && !fl_global &&
                 (peer_port_down || (peer_up_q && !peer_node_up_i))) begin
      next_fl_global = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snap_peer <= '0;
      own_ord   <= 1'b0;
      fl_known  <= 1'b0;
      fl_global <= 1'b0;
    end else begin
      snap_peer <= next_snap_peer;
      own_ord   <= next_own_ord;
      fl_known  <= next_fl_known;
      fl_global <= next_fl_global;
    end
  end

  // ==========================================================================
  // Egress eligibility and status outputs
  logic next_egr_allow;
  logic next_egr_allow_valid;

  // Two nodes at most, so VLAN mod count is the VLAN's low bit
  always_comb begin
    next_egr_allow_valid = egr_valid_i;
    if (!loc_seg[egr_client_i]) begin
      next_egr_allow = 1'b0;
    end else if (!lb_enable_i) begin
      next_egr_allow = fl_global;
    end else if (!snap_peer[egr_client_i]) begin
      next_egr_allow = 1'b1;
    end else begin
      next_egr_allow = (egr_vlan_i[0] == own_ord);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      egr_allow_o       <= 1'b0;
      egr_allow_valid_o <= 1'b0;
      fl_global_o       <= 1'b0;
      elect_busy_o      <= 1'b0;
    end else begin
      egr_allow_o       <= next_egr_allow;
      egr_allow_valid_o <= next_egr_allow_valid;
      fl_global_o       <= next_fl_global;
      elect_busy_o      <= (next_state != ST_IDLE);
    end
  end

endmodule

/* tb/pnl_chk.sv */
// Checker binding output relations of the peer-link block to their causes
`timescale 1ns/1ps
module pnl_chk (
  // Clock and reset
  input wire logic              clk_sys_i,
  input wire logic              rst_n_i,
  // Requests
  input wire logic              in_valid_i,
  input pnl_pkg::pnl_ingress_s  in_desc_i,
  input wire logic              rx_valid_i,
  input pnl_pkg::pnl_nsh_s      rx_hdr_i,
  input wire logic              cl_evt_valid_i,
  input wire logic [8:0]        cl_evt_client_i,
  input wire logic              seg_fail_valid_i,
  input wire logic              rt_rx_valid_i,
  input pnl_pkg::pnl_route_s    rt_rx_i,
  // Answers
  input pnl_pkg::pnl_nsh_s      nsh_o,
  input wire logic              nsh_valid_o,
  input wire logic              local_l2_o,
  input pnl_pkg::pnl_rx_s       rx_dec_o,
  input wire logic              rx_dec_valid_o,
  input pnl_pkg::pnl_route_s    rt_tx_o,
  input wire logic              rt_tx_valid_o,
  input wire logic              mac_flush_o,
  input wire logic [8:0]        mac_flush_client_o
);
  import pnl_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Steps that start a behaviour
  sequence s_tx;
    in_valid_i && in_desc_i.to_peer;
  endsequence
  sequence s_ad_wd;
    rt_rx_valid_i && rt_rx_i.rtype == RT_AUTO_DISC && rt_rx_i.withdraw;
  endsequence
  // ==========================================================================
  // Header toward the peer link, one cycle after the frame is taken
  property p_hdr;
    s_tx |=> nsh_valid_o && !local_l2_o &&
      nsh_o.bridge_domain == {4'h0, $past(in_desc_i.vlan)};
  endproperty
  a_hdr: assert property (p_hdr) else $error("header vlan wrong");
  property p_edge;
    s_tx ##0 in_desc_i.from_edge |=> nsh_o.tag == TAG_EDGE &&
      nsh_o.mflag == $past(in_desc_i.flood);
  endproperty
  a_edge: assert property (p_edge) else $error("edge tag wrong");
  property p_client;
    s_tx ##0 !in_desc_i.from_edge |=> nsh_o.mflag == $past(in_desc_i.flood)
      && nsh_o.tag == {7'h0, $past(in_desc_i.client)};
  endproperty
  a_client: assert property (p_client) else $error("client tag wrong");
  property p_local;
    in_valid_i && !in_desc_i.to_peer |=> local_l2_o && !nsh_valid_o;
  endproperty
  a_local: assert property (p_local) else $error("local frame wrong");
  // ==========================================================================
  // Decisions on frames from the peer link; learning never allowed
  property p_rx;
    rx_valid_i |=> rx_dec_valid_o && !rx_dec_o.learn &&
      rx_dec_o.unicast == !$past(rx_hdr_i.mflag) &&
      rx_dec_o.flood_group_id ==
      (FGID_BASE | {4'h0, $past(rx_hdr_i.bridge_domain[11:0])});
  endproperty
  a_rx: assert property (p_rx) else $error("rx group wrong");
  property p_supp;
    rx_valid_i && rx_hdr_i.mflag |=> rx_dec_o.flood &&
      rx_dec_o.suppress_en == ($past(rx_hdr_i.tag) != TAG_EDGE) &&
      rx_dec_o.suppress_client == $past(rx_hdr_i.tag[8:0]);
  endproperty
  a_supp: assert property (p_supp) else $error("suppression wrong");
  // ==========================================================================
  // Route events
  property p_flush;
    s_ad_wd |=> mac_flush_o && mac_flush_client_o == $past(rt_rx_i.client);
  endproperty
  a_flush: assert property (p_flush) else $error("flush missing");
  property p_segfail;
    seg_fail_valid_i |=> rt_tx_valid_o && rt_tx_o.withdraw &&
      rt_tx_o.rtype == RT_SEGMENT && rt_tx_o.len == RT_SEG_LEN;
  endproperty
  a_segfail: assert property (p_segfail) else $error("no withdraw");
  property p_deploy;
    cl_evt_valid_i && !seg_fail_valid_i |=> rt_tx_valid_o &&
      rt_tx_o.rtype == RT_SEGMENT && rt_tx_o.client == $past(cl_evt_client_i);
  endproperty
  a_deploy: assert property (p_deploy) else $error("no update");
endmodule
bind pnl_peer_link_fl pnl_chk u_chk (.*);

/* tb/pnl_peer_model.sv */
// Peer switch model sending frames and routes across the peer link
`timescale 1ns/1ps
module pnl_peer_model (
  // Clock
  input  wire logic            clk_sys_i,
  // Toward the block
  output logic                 rx_valid_o,
  output pnl_pkg::pnl_nsh_s    rx_hdr_o,
  output logic                 rt_valid_o,
  output pnl_pkg::pnl_route_s  rt_o
);
  import pnl_pkg::*;
  // Idle payload is junk so a stale value never looks valid
  initial begin
    rx_valid_o = 1'b0;
    rx_hdr_o   = '1;
    rt_valid_o = 1'b0;
    rt_o       = '1;
  end
  // Encapsulated frame, optionally after a delay of gap cycles
  task automatic send_frame(input int gap, input logic [11:0] vl,
                            input logic fl, input logic [15:0] tg);
    // Caller already stands just after an edge when no gap is asked
    if (gap > 0) begin
      repeat (gap) @(posedge clk_sys_i);
      #5;
    end
    rx_hdr_o   = '{bridge_domain: {4'h0, vl}, mflag: fl, tag: tg};
    rx_valid_o = 1'b1;
    @(posedge clk_sys_i);
    #5;
    rx_valid_o = 1'b0;
    rx_hdr_o   = ~rx_hdr_o;
  endtask
  // Route entry: type octet, length octet, then the body
  task automatic send_route(input int gap, input logic [7:0] ty,
                            input logic wd, input logic [8:0] cl);
    if (gap > 0) begin
      repeat (gap) @(posedge clk_sys_i);
      #5;
    end
    rt_o.rtype    = ty;
    rt_o.len      = (ty == RT_AUTO_DISC) ? RT_AD_LEN : RT_SEG_LEN;
    rt_o.withdraw = wd;
    rt_o.client   = cl;
    rt_valid_o    = 1'b1;
    @(posedge clk_sys_i);
    #5;
    rt_valid_o = 1'b0;
    rt_o       = ~rt_o;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the peer-link framer and election block
`timescale 1ns/1ps
module testbench;
  import pnl_pkg::*;
  localparam int W = 20;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, lb_enable_i = 1'b0;
  logic peer_node_up_i = 1'b0, session_up_i = 1'b0, in_valid_i = 1'b0;
  logic [31:0] own_ip_i = 32'h0a00_0002, peer_ip_i = 32'h0a00_0001;
  logic cl_evt_valid_i = 1'b0, cl_evt_deploy_i = 1'b0, egr_valid_i = 1'b0;
  logic port_evt_valid_i = 1'b0, port_evt_up_i = 1'b0;
  logic seg_fail_valid_i = 1'b0;
  logic [8:0] cl_evt_client_i = '0, port_evt_client_i = '0, cl;
  logic [8:0] seg_fail_client_i = '0, egr_client_i = '0, mac_flush_client_o;
  logic [11:0] egr_vlan_i = '0;
  pnl_ingress_s in_desc_i = '0;
  pnl_nsh_s rx_hdr_i, nsh_o;
  pnl_route_s rt_rx_i, rt_tx_o;
  pnl_rx_s rx_dec_o;
  logic rx_valid_i, rt_rx_valid_i, nsh_valid_o, local_l2_o, rx_dec_valid_o;
  logic rt_tx_valid_o, mac_flush_o, egr_allow_o, egr_allow_valid_o;
  logic fl_global_o, elect_busy_o;
  int miscompares = 0, num_checks = 0, cycles = 0;
  pnl_peer_link_fl #(.WAIT_CYCLES(W)) u_dut (.*);
  pnl_peer_model u_peer (.clk_sys_i, .rx_valid_o(rx_valid_i),
    .rx_hdr_o(rx_hdr_i), .rt_valid_o(rt_rx_valid_i), .rt_o(rt_rx_i));
  // ==========================================================================
  // Clock and hang guard
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done();
    end
  end
  // ==========================================================================
  // Helpers
  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys_i);
    #5;
  endtask
  // Strobe stays up between back-to-back frames
  task automatic frame(input logic fl, ed, tp, input logic [8:0] c,
                       input logic [11:0] vl);
    in_desc_i  = '{flood: fl, from_edge: ed, to_peer: tp, client: c, vlan: vl};
    in_valid_i = 1'b1;
    tick();
  endtask
  task automatic rt_chk(input logic [7:0] ty, len, input logic wd);
    chk("rt_valid", rt_tx_valid_o, 1);
    chk("rt_type", rt_tx_o.rtype, ty);
    chk("rt_len", rt_tx_o.len, len);
    chk("rt_wd", rt_tx_o.withdraw, wd);
    chk("rt_client", rt_tx_o.client, 5);
  endtask
  task automatic ask(input logic [8:0] c, input logic [11:0] vl, input ex);
    egr_client_i = c;
    egr_vlan_i   = vl;
    egr_valid_i  = 1'b1;
    tick();
    chk("allow_valid", egr_allow_valid_o, 1);
    chk("allow", egr_allow_o, ex);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    tick(5);
    rst_n_i = 1'b1;
    tick();
    // Edge and client, flood and unicast, largest client id included
    for (int i = 0; i < 4; i++) begin
      cl = i[0] ? 9'h1ff : 9'd10;
      frame(i[0], i[1], 1'b1, cl, 12'd5 + 12'(i));
      chk("nsh_valid", nsh_valid_o, 1);
      chk("bd", nsh_o.bridge_domain, 5 + i);
      chk("tag", nsh_o.tag, i[1] ? TAG_EDGE : {7'h0, cl});
      chk("mflag", nsh_o.mflag, i[0]);
    end
    frame(1'b0, 1'b1, 1'b0, 9'd0, 12'd3);
    in_valid_i = 1'b0;
    chk("local", local_l2_o, 1);
    chk("no_nsh", nsh_valid_o, 0);
    // Peer frames: client tag suppresses, edge tag does not
    u_peer.send_frame(0, 12'd7, 1'b1, 16'd10);
    chk("fgid", rx_dec_o.flood_group_id, 16'h1007);
    chk("supp", rx_dec_o.suppress_en, 1);
    chk("supp_cl", rx_dec_o.suppress_client, 10);
    chk("learn", rx_dec_o.learn, 0);
    u_peer.send_frame(1, 12'd8, 1'b1, TAG_EDGE);
    chk("edge_supp", rx_dec_o.suppress_en, 0);
    chk("edge_fgid", rx_dec_o.flood_group_id, 16'h1008);
    // Deploy starts the wait; single flooder once it expires
    cl_evt_valid_i  = 1'b1;
    cl_evt_deploy_i = 1'b1;
    cl_evt_client_i = 9'd5;
    tick();
    cl_evt_valid_i = 1'b0;
    rt_chk(RT_SEGMENT, RT_SEG_LEN, 1'b0);
    chk("busy", elect_busy_o, 1);
    tick(W / 2);
    chk("busy_wait", elect_busy_o, 1);
    tick(W / 2 + 4);
    chk("busy_end", elect_busy_o, 0);
    chk("fl", fl_global_o, 1);
    ask(9'd5, 12'd4, 1'b1);
    ask(9'd6, 12'd4, 1'b0);
    egr_valid_i = 1'b0;
    // Own client port down withdraws discovery and drops the flooder
    port_evt_valid_i  = 1'b1;
    port_evt_client_i = 9'd5;
    tick();
    port_evt_valid_i = 1'b0;
    rt_chk(RT_AUTO_DISC, RT_AD_LEN, 1'b1);
    tick(3);
    chk("fl_down", fl_global_o, 0);
    u_peer.send_route(0, RT_AUTO_DISC, 1'b1, 9'd5);
    chk("flush", mac_flush_o, 1);
    chk("flush_cl", mac_flush_client_o, 5);
    tick(3);
    chk("fl_up", fl_global_o, 1);
    u_peer.send_route(0, RT_MAC_IP, 1'b1, 9'd5);
    chk("no_flush", mac_flush_o, 0);
    // Balancing on, higher own address takes ordinal one
    port_evt_up_i    = 1'b1;
    port_evt_valid_i = 1'b1;
    tick();
    port_evt_valid_i = 1'b0;
    rt_chk(RT_AUTO_DISC, RT_AD_LEN, 1'b0);
    lb_enable_i    = 1'b1;
    peer_node_up_i = 1'b1;
    u_peer.send_route(3, RT_SEGMENT, 1'b0, 9'd5);
    tick(4);
    ask(9'd5, 12'd5, 1'b1);
    ask(9'd5, 12'd4, 1'b0);
    egr_valid_i = 1'b0;
    seg_fail_valid_i  = 1'b1;
    seg_fail_client_i = 9'd5;
    tick();
    seg_fail_valid_i = 1'b0;
    rt_chk(RT_SEGMENT, RT_SEG_LEN, 1'b1);
    tick(4);
    ask(9'd5, 12'd5, 1'b0);
    egr_valid_i = 1'b0;
    // Control session coming up starts the wait from idle
    session_up_i = 1'b1;
    tick();
    chk("busy_sess", elect_busy_o, 1);
    test_done();
  end
endmodule
